// ### core/special_function_reg_bank.sv
// Behaviour
// - Enables sit in bytes 00h-0Fh; unassigned bits have no storage.
// - Watchdog irq enable gates the interrupt only in interval timer mode.
// - Watchdog flag sets on counter overflow or on a bad key write.
// - Watchdog flag clears on power-on and on a pin reset in reset mode.
// - Oscillator fault flag sets whenever the clock system reports a fault.
// - Nonmaskable flag sets on an event at the shared reset pin.
// - Own enables for oscillator fault, nonmaskable pin, flash violation.
// - Serial rx and tx enables apply in async and sync operation.
// - Byte 03h: tx flag bit 1, rx flag bit 0; power-up clear zeroes both.
// - Byte 05h: bit 1 async tx enable, bit 0 async rx or sync both.
// - Plain bits reset by power-up clear, bracketed bits by power-on only.
// - Overflow asks a system reset in reset mode, an irq in interval mode.
`timescale 1ns/1ps
`default_nettype none

module special_function_reg_bank
    import sfr_bank_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and power-on reset
    input  wire logic              sys_clk_in,
    input  wire logic              arst_n_in,
    // System power-up clear, one-cycle pulse
    input  wire logic              power_up_clear_in,
    // Peripheral bus, byte access
    input  wire logic [ADDR_W-1:0] bus_addr_in,
    input  wire logic [7:0]        bus_wdata_in,
    input  wire logic              bus_wr_in,
    input  wire logic              bus_rd_in,
    output logic      [7:0]        bus_rdata_out,
    // Watchdog unit status
    input  wire logic              wdog_interval_mode_in,
    input  wire logic              wdog_overflow_in,
    input  wire logic              wdog_key_violation_in,
    // Shared reset/nonmaskable pin and clock system
    input  wire logic              pin_reset_in,
    input  wire logic              nmi_pin_event_in,
    input  wire logic              osc_fault_in,
    input  wire logic              flash_violation_in,
    // Serial port events
    input  wire logic              serial_rx_event_in,
    input  wire logic              serial_tx_event_in,
    // Interrupt requests and watchdog reset
    output logic                   wdog_irq_out,
    output logic                   wdog_reset_req_out,
    output logic                   osc_fault_irq_out,
    output logic                   nmi_pin_irq_out,
    output logic                   flash_violation_irq_out,
    output logic                   serial_rx_irq_out,
    output logic                   serial_tx_irq_out,
    // Serial port module enables
    output logic                   async_tx_enable_out,
    output logic                   async_rx_enable_out
);

    // Offsets 00h to 0Fh must fit in the address port
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("ADDR_W must cover offsets 00h to 0Fh");
    end

    // Only implemented bits exist as storage
    logic wdog_irq_en;
    logic osc_fault_irq_en;
    logic nmi_pin_irq_en;
    logic flash_violation_irq_en;
    logic serial_rx_irq_en;
    logic serial_tx_irq_en;
    logic wdog_irq_flag;
    logic osc_fault_flag;
    logic nmi_pin_flag;
    logic serial_rx_flag;
    logic serial_tx_flag;
    logic async_tx_enable;
    logic async_rx_enable;             // Also the sync transmit/receive enable

    // Region flag and one write strobe per implemented byte
    logic in_region;
    logic wr_en1;
    logic wr_en2;
    logic wr_flag1;
    logic wr_flag2;
    logic wr_mod2;

    // Set wins over a software write in the same cycle
    function automatic logic flag_next(input logic cur, input logic wr,
                                       input logic wbit, input logic set);
        flag_next = set | (wr ? wbit : cur);
    endfunction : flag_next

    // Plain register bit update on write
    function automatic logic bit_next(input logic cur, input logic wr,
                                      input logic wbit);
        bit_next = wr ? wbit : cur;
    endfunction : bit_next

    // Address decode, only the low sixteen bytes belong to the bank
    assign in_region = (bus_addr_in <= ADDR_W'(OFS_LAST));
    assign wr_en1    = bus_wr_in && bus_addr_in == ADDR_W'(OFS_IRQ_EN1);
    assign wr_en2    = bus_wr_in && bus_addr_in == ADDR_W'(OFS_IRQ_EN2);
    assign wr_flag1  = bus_wr_in && bus_addr_in == ADDR_W'(OFS_IRQ_FLAG1);
    assign wr_flag2  = bus_wr_in && bus_addr_in == ADDR_W'(OFS_IRQ_FLAG2);
    assign wr_mod2   = bus_wr_in && bus_addr_in == ADDR_W'(OFS_MOD_EN2);

    // Byte 00h enables, cleared by power-up clear
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdog_irq_en            <= RST_BIT;
            osc_fault_irq_en       <= RST_BIT;
            nmi_pin_irq_en         <= RST_BIT;
            flash_violation_irq_en <= RST_BIT;
        end else if (power_up_clear_in) begin
            wdog_irq_en            <= RST_BIT;
            osc_fault_irq_en       <= RST_BIT;
            nmi_pin_irq_en         <= RST_BIT;
            flash_violation_irq_en <= RST_BIT;
        end else begin
            wdog_irq_en <= bit_next(wdog_irq_en, wr_en1,
                                    bus_wdata_in[BIT_WDOG]);
            osc_fault_irq_en <= bit_next(osc_fault_irq_en, wr_en1,
                                         bus_wdata_in[BIT_OSC_FAULT]);
            nmi_pin_irq_en <= bit_next(nmi_pin_irq_en, wr_en1,
                                       bus_wdata_in[BIT_NMI_PIN]);
            flash_violation_irq_en <= bit_next(flash_violation_irq_en, wr_en1,
                                       bus_wdata_in[BIT_FLASH_VIO]);
        end
    end

    // Byte 01h serial enables, cleared by power-up clear
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_rx_irq_en <= RST_BIT;
            serial_tx_irq_en <= RST_BIT;
        end else if (power_up_clear_in) begin
            serial_rx_irq_en <= RST_BIT;
            serial_tx_irq_en <= RST_BIT;
        end else begin
            serial_rx_irq_en <= bit_next(serial_rx_irq_en, wr_en2,
                                         bus_wdata_in[BIT_SER_RX]);
            serial_tx_irq_en <= bit_next(serial_tx_irq_en, wr_en2,
                                         bus_wdata_in[BIT_SER_TX]);
        end
    end

    // Watchdog flag survives power-up clear; cleared by power-on or pin reset
    // Pin reset beats a set in the same cycle
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdog_irq_flag <= RST_BIT;
        end else if (pin_reset_in) begin
            wdog_irq_flag <= RST_BIT;
        end else begin
            wdog_irq_flag <= flag_next(wdog_irq_flag, wr_flag1,
                                       bus_wdata_in[BIT_WDOG],
                                       wdog_overflow_in
                                       | wdog_key_violation_in);
        end
    end

    // Oscillator fault flag; a fault still present during clear sets it again
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            osc_fault_flag <= RST_BIT;
        end else if (power_up_clear_in) begin
            osc_fault_flag <= osc_fault_in;
        end else begin
            osc_fault_flag <= flag_next(osc_fault_flag, wr_flag1,
                                        bus_wdata_in[BIT_OSC_FAULT],
                                        osc_fault_in);
        end
    end

    // Nonmaskable pin flag
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nmi_pin_flag <= RST_BIT;
        end else if (power_up_clear_in) begin
            nmi_pin_flag <= RST_BIT;
        end else begin
            nmi_pin_flag <= flag_next(nmi_pin_flag, wr_flag1,
                                      bus_wdata_in[BIT_NMI_PIN],
                                      nmi_pin_event_in);
        end
    end

    // Serial flags at byte 03h
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_rx_flag <= RST_BIT;
            serial_tx_flag <= RST_BIT;
        end else if (power_up_clear_in) begin
            serial_rx_flag <= RST_BIT;
            serial_tx_flag <= RST_BIT;
        end else begin
            serial_rx_flag <= flag_next(serial_rx_flag, wr_flag2,
                                        bus_wdata_in[BIT_SER_RX],
                                        serial_rx_event_in);
            serial_tx_flag <= flag_next(serial_tx_flag, wr_flag2,
                                        bus_wdata_in[BIT_SER_TX],
                                        serial_tx_event_in);
        end
    end

    // Serial module enables at byte 05h
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            async_tx_enable <= RST_BIT;
            async_rx_enable <= RST_BIT;
        end else if (power_up_clear_in) begin
            async_tx_enable <= RST_BIT;
            async_rx_enable <= RST_BIT;
        end else begin
            async_tx_enable <= bit_next(async_tx_enable, wr_mod2,
                                        bus_wdata_in[BIT_SER_TX]);
            async_rx_enable <= bit_next(async_rx_enable, wr_mod2,
                                        bus_wdata_in[BIT_SER_RX]);
        end
    end

    // Read data, absent bits and empty bytes read zero
    // A read in the cycle of a write returns the old value
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_rdata_out <= RDATA_RST;
        end else if (bus_rd_in && in_region) begin
            bus_rdata_out <= RDATA_RST;
            case (bus_addr_in[3:0])
                OFS_IRQ_EN1: begin
                    bus_rdata_out[BIT_WDOG]      <= wdog_irq_en;
                    bus_rdata_out[BIT_OSC_FAULT] <= osc_fault_irq_en;
                    bus_rdata_out[BIT_NMI_PIN]   <= nmi_pin_irq_en;
                    bus_rdata_out[BIT_FLASH_VIO] <= flash_violation_irq_en;
                end
                OFS_IRQ_EN2: begin
                    bus_rdata_out[BIT_SER_RX] <= serial_rx_irq_en;
                    bus_rdata_out[BIT_SER_TX] <= serial_tx_irq_en;
                end
                OFS_IRQ_FLAG1: begin
                    bus_rdata_out[BIT_WDOG]      <= wdog_irq_flag;
                    bus_rdata_out[BIT_OSC_FAULT] <= osc_fault_flag;
                    bus_rdata_out[BIT_NMI_PIN]   <= nmi_pin_flag;
                end
                OFS_IRQ_FLAG2: begin
                    bus_rdata_out[BIT_SER_RX] <= serial_rx_flag;
                    bus_rdata_out[BIT_SER_TX] <= serial_tx_flag;
                end
                OFS_MOD_EN2: begin
                    bus_rdata_out[BIT_SER_RX] <= async_rx_enable;
                    bus_rdata_out[BIT_SER_TX] <= async_tx_enable;
                end
                default: begin
                    bus_rdata_out <= RDATA_RST;
                end
            endcase
        end else if (bus_rd_in) begin
            bus_rdata_out <= RDATA_RST;
        end
    end

    // System interrupt requests gated by their enables
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdog_irq_out            <= RST_BIT;
            osc_fault_irq_out       <= RST_BIT;
            nmi_pin_irq_out         <= RST_BIT;
            flash_violation_irq_out <= RST_BIT;
        end else begin
            wdog_irq_out <= wdog_irq_flag & wdog_irq_en
                            & wdog_interval_mode_in;
            osc_fault_irq_out <= osc_fault_flag & osc_fault_irq_en;
            nmi_pin_irq_out <= nmi_pin_flag & nmi_pin_irq_en;
            flash_violation_irq_out <= flash_violation_in
                                       & flash_violation_irq_en;
        end
    end

    // Serial interrupt requests gated by their enables
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_rx_irq_out <= RST_BIT;
            serial_tx_irq_out <= RST_BIT;
        end else begin
            serial_rx_irq_out <= serial_rx_flag & serial_rx_irq_en;
            serial_tx_irq_out <= serial_tx_flag & serial_tx_irq_en;
        end
    end

    // Watchdog reset request, only in reset mode
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wdog_reset_req_out <= RST_BIT;
        end else begin
            wdog_reset_req_out <= wdog_overflow_in
                                  & ~wdog_interval_mode_in;
        end
    end

    // Module enable copies for the serial port
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            async_tx_enable_out <= RST_BIT;
            async_rx_enable_out <= RST_BIT;
        end else begin
            async_tx_enable_out <= async_tx_enable;
            async_rx_enable_out <= async_rx_enable;
        end
    end

endmodule : special_function_reg_bank

`default_nettype wire

// ### core/sfr_bank_pkg.sv
package sfr_bank_pkg;

    // Byte offsets inside the special function region
    localparam logic [3:0] OFS_IRQ_EN1   = 4'h0;
    localparam logic [3:0] OFS_IRQ_EN2   = 4'h1;
    localparam logic [3:0] OFS_IRQ_FLAG1 = 4'h2;
    localparam logic [3:0] OFS_IRQ_FLAG2 = 4'h3;
    localparam logic [3:0] OFS_MOD_EN1   = 4'h4;
    localparam logic [3:0] OFS_MOD_EN2   = 4'h5;
    localparam logic [3:0] OFS_LAST      = 4'hF;

    // Bit positions in interrupt enable 1 and flag 1
    localparam int BIT_WDOG      = 0;
    localparam int BIT_OSC_FAULT = 1;
    localparam int BIT_NMI_PIN   = 4;
    localparam int BIT_FLASH_VIO = 5;

    // Bit positions in interrupt enable 2, flag 2 and module enable 2
    localparam int BIT_SER_RX    = 0;
    localparam int BIT_SER_TX    = 1;

    // Values forced by the power-up clear and the power-on reset
    localparam logic       RST_BIT    = 1'b0;
    localparam logic [7:0] RDATA_RST  = 8'h00;

endpackage : sfr_bank_pkg

// ### verif/special_function_reg_bank_props.sv
`timescale 1ns/1ps
`default_nettype none

module special_function_reg_bank_props #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic              sys_clk_in,
    input wire logic              arst_n_in,
    input wire logic              power_up_clear_in,
    // Bus and sources
    input wire logic [ADDR_W-1:0] bus_addr_in,
    input wire logic [7:0]        bus_wdata_in,
    input wire logic              bus_wr_in,
    input wire logic              bus_rd_in,
    input wire logic              wdog_interval_mode_in,
    input wire logic              wdog_overflow_in,
    input wire logic              pin_reset_in,
    input wire logic              flash_violation_in,
    // Watched outputs
    input wire logic [7:0]        bus_rdata_out,
    input wire logic              wdog_irq_out,
    input wire logic              wdog_reset_req_out,
    input wire logic              flash_violation_irq_out,
    input wire logic              async_tx_enable_out,
    input wire logic              async_rx_enable_out
);
    logic [7:0] wd_q;
    logic [7:0] wd_qq;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // Write data two cycles back, for the module enable copy
    always_ff @(posedge sys_clk_in) begin
        wd_q  <= bus_wdata_in;
        wd_qq <= wd_q;
    end

    a_rd_empty_byte: assert property (
        bus_rd_in && bus_addr_in == 4'h4 |=> bus_rdata_out == 8'h00)
        else $error("empty byte read nonzero");
    a_rd_upper_zero: assert property (
        bus_rd_in && bus_addr_in > 4'h5 |=> bus_rdata_out == 8'h00)
        else $error("unused byte read nonzero");
    a_enable_copy: assert property (
        bus_wr_in && bus_addr_in == 4'h5 && !power_up_clear_in |=> ##1
        {async_tx_enable_out, async_rx_enable_out} == wd_qq[1:0])
        else $error("module enable outputs wrong");
    a_reset_req_set: assert property (
        wdog_overflow_in && !wdog_interval_mode_in |=> wdog_reset_req_out)
        else $error("no reset request on overflow");
    a_reset_req_idle: assert property (
        !wdog_overflow_in || wdog_interval_mode_in |=> !wdog_reset_req_out)
        else $error("spurious reset request");
    a_wdog_mode_gate: assert property (
        !wdog_interval_mode_in |=> !wdog_irq_out)
        else $error("watchdog irq in reset mode");
    a_flash_gate: assert property (
        !flash_violation_in |=> !flash_violation_irq_out)
        else $error("flash irq without violation");
    a_pin_clear: assert property (
        pin_reset_in |=> ##1 !wdog_irq_out)
        else $error("watchdog irq after pin reset");
endmodule : special_function_reg_bank_props

bind special_function_reg_bank special_function_reg_bank_props #(
    .ADDR_W(ADDR_W)
) u_props (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .power_up_clear_in(power_up_clear_in), .bus_addr_in(bus_addr_in),
    .bus_wdata_in(bus_wdata_in), .bus_wr_in(bus_wr_in),
    .bus_rd_in(bus_rd_in), .wdog_interval_mode_in(wdog_interval_mode_in),
    .wdog_overflow_in(wdog_overflow_in), .pin_reset_in(pin_reset_in),
    .flash_violation_in(flash_violation_in), .bus_rdata_out(bus_rdata_out),
    .wdog_irq_out(wdog_irq_out), .wdog_reset_req_out(wdog_reset_req_out),
    .flash_violation_irq_out(flash_violation_irq_out),
    .async_tx_enable_out(async_tx_enable_out),
    .async_rx_enable_out(async_rx_enable_out)
);

`default_nettype wire

// ### verif/special_function_reg_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none

module special_function_reg_bank_bench;
    logic       sys_clk, arst_n, power_up_clear, wr, rd, mode, pin_rst, flash_v, rreq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic [5:0] ev;
    wire  [5:0] irq;
    wire  [1:0] en_out;
    logic [7:0] m [6];
    logic [7:0] mk [6] = '{8'h33, 8'h03, 8'h13, 8'h03, 8'h00, 8'h03};
    int         num_errors, n_checks, cyc;
    integer     seed;

    special_function_reg_bank u_dut (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .power_up_clear_in(power_up_clear),
        .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_wr_in(wr),
        .bus_rd_in(rd), .bus_rdata_out(rdata), .wdog_interval_mode_in(mode),
        .wdog_overflow_in(ev[4]), .wdog_key_violation_in(ev[5]),
        .pin_reset_in(pin_rst), .nmi_pin_event_in(ev[2]),
        .osc_fault_in(ev[3]), .flash_violation_in(flash_v),
        .serial_rx_event_in(ev[0]), .serial_tx_event_in(ev[1]),
        .wdog_irq_out(irq[0]), .wdog_reset_req_out(rreq),
        .osc_fault_irq_out(irq[1]), .nmi_pin_irq_out(irq[2]),
        .flash_violation_irq_out(irq[3]), .serial_rx_irq_out(irq[4]),
        .serial_tx_irq_out(irq[5]), .async_tx_enable_out(en_out[1]),
        .async_rx_enable_out(en_out[0])
    );

    // Clock and hang guard
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc > 3000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Bus cycles, each one clock wide, driven on falling edges
    task automatic wr_b(input logic [3:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
        if (a < 4'h6) m[a] = d & mk[a];
    endtask : wr_b

    task automatic rd_b(input logic [3:0] a);
        @(negedge sys_clk);
        addr = a;
        rd = 1'b1;
        @(negedge sys_clk);
        rd = 1'b0;
        chk("rdata", rdata, (a < 4'h6) ? m[a] : 8'h00);
    endtask : rd_b

    // One-cycle source events; the model sets the matching flags
    task automatic pulse(input logic [5:0] b);
        @(negedge sys_clk);
        ev = b;
        @(negedge sys_clk);
        ev = 6'h00;
        m[3] |= {6'h00, b[1:0]};
        m[2] |= {3'h0, b[2], 2'h0, b[3], b[4] | b[5]};
    endtask : pulse

    task automatic irq_chk;
        logic [7:0] e;
        @(negedge sys_clk);
        e = {2'b00, m[3][1] & m[1][1], m[3][0] & m[1][0], flash_v & m[0][5],
             m[2][4] & m[0][4], m[2][1] & m[0][1], m[2][0] & m[0][0] & mode};
        chk("irq", {2'b00, irq}, e);
    endtask : irq_chk

    task automatic complete_run;
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    initial begin
        {sys_clk, arst_n, power_up_clear, wr, rd, mode, pin_rst, flash_v} = 8'h00;
        {addr, wdata, ev} = 18'h00000;
        num_errors = 0;
        n_checks = 0;
        cyc = 0;
        seed = 16629;
        for (int i = 0; i < 6; i++) m[i] = 8'h00;
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        // Reset values over the whole region
        for (int a = 0; a < 16; a++) rd_b(a[3:0]);
        // Random writes read back, module enables followed
        repeat (24) begin
            wr_b(4'($random(seed)), 8'($random(seed)));
            rd_b(addr);
            chk("en", {6'h00, en_out}, {6'h00, m[5][1:0]});
        end
        // Every source in interval mode with all enables set
        wr_b(4'h0, 8'hFF);
        wr_b(4'h1, 8'hFF);
        mode = 1'b1;
        flash_v = 1'b1;
        for (int k = 0; k < 6; k++) begin
            wr_b(4'h2, 8'h00);
            wr_b(4'h3, 8'h00);
            pulse(6'h01 << k);
            chk("rreq", {7'h00, rreq}, 8'h00);
            irq_chk();
            rd_b(4'h2);
            rd_b(4'h3);
        end
        // Reset mode: enable ignored, overflow asks for a reset
        mode = 1'b0;
        flash_v = 1'b0;
        irq_chk();
        pulse(6'h10);
        chk("rreq", {7'h00, rreq}, 8'h01);
        irq_chk();
        chk("rreq", {7'h00, rreq}, 8'h00);
        // Enables cleared mask every pending flag
        wr_b(4'h0, 8'h00);
        wr_b(4'h1, 8'h00);
        mode = 1'b1;
        flash_v = 1'b1;
        irq_chk();
        // Power-up clear keeps only the watchdog flag
        wr_b(4'h0, 8'hFF);
        wr_b(4'h5, 8'h03);
        @(negedge sys_clk);
        power_up_clear = 1'b1;
        @(negedge sys_clk);
        power_up_clear = 1'b0;
        for (int i = 0; i < 6; i++) m[i] = (i == 2) ? (m[2] & 8'h01) : 8'h00;
        for (int a = 0; a < 6; a++) rd_b(a[3:0]);
        chk("en", {6'h00, en_out}, 8'h00);
        // Pin reset clears the watchdog flag and its pending request
        wr_b(4'h0, 8'h01);
        irq_chk();
        @(negedge sys_clk);
        pin_rst = 1'b1;
        @(negedge sys_clk);
        pin_rst = 1'b0;
        m[2][0] = 1'b0;
        rd_b(4'h2);
        irq_chk();
        // Power-on reset in mid-run clears everything
        wr_b(4'h3, 8'h03);
        pulse(6'h10);
        arst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        arst_n = 1'b1;
        for (int i = 0; i < 6; i++) m[i] = 8'h00;
        for (int a = 0; a < 6; a++) rd_b(a[3:0]);
        complete_run();
    end
endmodule : special_function_reg_bank_bench

`default_nettype wire
